// *** hw/lcr_pkg.sv ***
// constants, field layout and carrier types of the link capabilities register bank
////////////////////////////////////////////////////////////////////////////////
// How it works
// - max link speed is read-only four bits, reset 0x1, code 1 or 2 valid.
// - max link width is six bits; 1, 2 and 4 lanes valid, others reserved.
// - software may overwrite max link width on the upstream port to train narrower.
// - a reserved or invalid width code makes the port use a single lane.
// - max link width loads the port's physical lane width at reset.
// - low power state support always reads 0x3, both L0s and L1.
// - l0s exit latency reads 0x5 while separate reference clocks are used.
// - l0s exit latency reads 0x3 while a shared reference clock is used.
// - shared refclk selection is a writable link control bit, reset zero.
// - l1 exit latency is a three-bit field with reset code 0x2.
// - reference clock removal tolerance bit resets to zero.
// - surprise down report bit resets one downstream, zero upstream.
// - link active report bit resets one downstream, zero upstream.
// - port number is a fixed eight-bit value per port.
package lcr_pkg;

   // register byte addresses
   localparam logic [11:0] LCR_LOCK_CTRL_OFS = 12'h040;
   localparam logic [11:0] LCR_LINK_CAPS_OFS = 12'h04c;
   localparam logic [11:0] LCR_LINK_CTRL_OFS = 12'h050;

   // field positions
   localparam int LCR_UNLOCK_BIT     = 0;
   localparam int LCR_SHARED_CLK_BIT = 6;

   // reset and fixed values
   localparam logic [3:0] LCR_SPEED_RESET   = 4'h1;
   localparam logic [3:0] LCR_SPEED_GEN1    = 4'h1;
   localparam logic [3:0] LCR_SPEED_GEN2    = 4'h2;
   localparam logic [1:0] LCR_LPS_SUPPORT   = 2'h3;
   localparam logic [2:0] LCR_L0S_SEPARATE  = 3'h5;
   localparam logic [2:0] LCR_L0S_COMMON    = 3'h3;
   localparam logic [2:0] LCR_L1_RESET      = 3'h2;
   localparam logic       LCR_CLK_RM_RESET  = 1'h0;
   localparam logic       LCR_SHARED_RESET  = 1'h0;
   localparam logic       LCR_UNLOCK_RESET  = 1'h0;
   localparam logic [2:0] LCR_RSVD_VALUE    = 3'h0;

   // width codes
   localparam logic [5:0] LCR_WIDTH_X1 = 6'h01;
   localparam logic [5:0] LCR_WIDTH_X2 = 6'h02;
   localparam logic [5:0] LCR_WIDTH_X4 = 6'h04;

   // capability word as read by software
   typedef struct packed {
      logic [7:0] port_number;
      logic [2:0] reserved;
      logic       link_active_report_cap;
      logic       surprise_down_report_cap;
      logic       ref_clock_removal_ok;
      logic [2:0] l1_exit_latency;
      logic [2:0] l0s_exit_latency;
      logic [1:0] low_power_state_support;
      logic [5:0] max_link_width;
      logic [3:0] max_link_speed;
   } lcr_caps_t;

   // apb request as seen by the slave
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
      logic [3:0]  pstrb;
   } lcr_apb_req_t;

endpackage

// *** hw/lcr_field.sv ***
// one lockable register field with byte-masked write
`timescale 1ns/1ns
module lcr_field #(
   parameter int             W         = 1,
   parameter logic [W-1:0]   RESET_VAL = '0
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic         we,
   input  wire logic [W-1:0] mask,
   input  wire logic [W-1:0] wdata,
   output logic      [W-1:0] q
);

   // masked merge keeps bits whose byte lane is not strobed
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         q <= RESET_VAL;
      end else if (we) begin
         q <= (q & ~mask) | (wdata & mask);
      end
   end

endmodule // lcr_field

// *** hw/lcr_width_fix.sv ***
// width code check: reserved codes or codes wider than the port fall back to x1
`timescale 1ns/1ns
module lcr_width_fix #(
   parameter logic [5:0] PHYS_WIDTH = 6'h04
) (
   input  wire logic [5:0] code,
   output logic      [5:0] width
);
   import lcr_pkg::*;

   logic legal;

   always_comb begin
      legal = (code == LCR_WIDTH_X1) || (code == LCR_WIDTH_X2) || (code == LCR_WIDTH_X4);
      width = (legal && (code <= PHYS_WIDTH)) ? code : LCR_WIDTH_X1;
   end

endmodule // lcr_width_fix

// *** hw/lcr_top.sv ***
// link capabilities register bank with apb slave, one instance per switch port
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ns
module lcr_top #(
   parameter bit         IS_UPSTREAM = 1'b1,
   parameter logic [5:0] PHYS_WIDTH  = 6'h04,
   parameter logic [7:0] PORT_NUM    = 8'h00,
   parameter logic [3:0] MAX_SPEED   = 4'h1
) (
   input  wire logic              CLOCK,
   input  wire logic              RESET,
   input  wire logic              PSEL,
   input  wire logic              PENABLE,
   input  wire logic              PWRITE,
   input  wire logic [11:0]       PADDR,
   input  wire logic [31:0]       PWDATA,
   input  wire logic [3:0]        PSTRB,
   output logic                   PREADY,
   output logic      [31:0]       PRDATA,
   output logic                   PSLVERR,
   output lcr_pkg::lcr_caps_t     LINK_CAPS,
   output logic      [5:0]        EFFECTIVE_WIDTH,
   output logic                   SHARED_REFCLK,
   output logic                   REG_UNLOCK
);
   import lcr_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // bus request and decode

   lcr_apb_req_t req;
   logic         setup;
   logic         access;
   logic         hit_lock;
   logic         hit_caps;
   logic         hit_ctrl;
   logic         mapped;
   logic [31:0]  wmask;
   logic         wr_lock;
   logic         wr_caps;
   logic         wr_ctrl;

   always_comb begin
      req.psel    = PSEL;
      req.penable = PENABLE;
      req.pwrite  = PWRITE;
      req.paddr   = PADDR;
      req.pwdata  = PWDATA;
      req.pstrb   = PSTRB;
   end

   assign setup    = req.psel & ~req.penable;
   assign access   = req.psel & req.penable;
   assign hit_lock = (req.paddr == LCR_LOCK_CTRL_OFS);
   assign hit_caps = (req.paddr == LCR_LINK_CAPS_OFS);
   assign hit_ctrl = (req.paddr == LCR_LINK_CTRL_OFS);
   assign mapped   = hit_lock | hit_caps | hit_ctrl;

   // byte lanes to bit mask
   assign wmask = {{8{req.pstrb[3]}}, {8{req.pstrb[2]}}, {8{req.pstrb[1]}}, {8{req.pstrb[0]}}};

   // writes take effect only at the completing access edge
   assign wr_lock = access & PREADY & req.pwrite & hit_lock;
   assign wr_caps = access & PREADY & req.pwrite & hit_caps;
   assign wr_ctrl = access & PREADY & req.pwrite & hit_ctrl;

   // zero wait states: every access completes in its first access cycle
   assign PREADY = 1'b1;

   ////////////////////////////////////////////////////////////////////////////
   // unlock and link control bits

   logic unlock;
   logic shared_refclk_config;
   logic width_we;
   logic locked_we;

   always_ff @(posedge CLOCK or posedge RESET) begin
      if (RESET) begin
         unlock <= LCR_UNLOCK_RESET;
      end else if (wr_lock && wmask[LCR_UNLOCK_BIT]) begin
         unlock <= req.pwdata[LCR_UNLOCK_BIT];
      end
   end

   always_ff @(posedge CLOCK or posedge RESET) begin
      if (RESET) begin
         shared_refclk_config <= LCR_SHARED_RESET;
      end else if (wr_ctrl && wmask[LCR_SHARED_CLK_BIT]) begin
         shared_refclk_config <= req.pwdata[LCR_SHARED_CLK_BIT];
      end
   end

   assign width_we  = wr_caps & (IS_UPSTREAM | unlock);
   assign locked_we = wr_caps & unlock;

   ////////////////////////////////////////////////////////////////////////////
   // capability fields

   lcr_caps_t wcaps;
   lcr_caps_t mcaps;
   lcr_caps_t caps;
   logic [5:0] width_q;
   logic [2:0] l1_q;
   logic       clk_rm_q;
   logic       sdown_q;
   logic       lact_q;

   assign wcaps = lcr_caps_t'(req.pwdata);
   assign mcaps = lcr_caps_t'(wmask);

   lcr_field #(.W(6), .RESET_VAL(PHYS_WIDTH)) u_width (
      .clk   (CLOCK),
      .rst   (RESET),
      .we    (width_we),
      .mask  (mcaps.max_link_width),
      .wdata (wcaps.max_link_width),
      .q     (width_q)
   );

   lcr_field #(.W(3), .RESET_VAL(LCR_L1_RESET)) u_l1 (
      .clk   (CLOCK),
      .rst   (RESET),
      .we    (locked_we),
      .mask  (mcaps.l1_exit_latency),
      .wdata (wcaps.l1_exit_latency),
      .q     (l1_q)
   );

   lcr_field #(.W(1), .RESET_VAL(LCR_CLK_RM_RESET)) u_clk_rm (
      .clk   (CLOCK),
      .rst   (RESET),
      .we    (locked_we),
      .mask  (mcaps.ref_clock_removal_ok),
      .wdata (wcaps.ref_clock_removal_ok),
      .q     (clk_rm_q)
   );

   lcr_field #(.W(1), .RESET_VAL(!IS_UPSTREAM)) u_sdown (
      .clk   (CLOCK),
      .rst   (RESET),
      .we    (locked_we),
      .mask  (mcaps.surprise_down_report_cap),
      .wdata (wcaps.surprise_down_report_cap),
      .q     (sdown_q)
   );

   lcr_field #(.W(1), .RESET_VAL(!IS_UPSTREAM)) u_lact (
      .clk   (CLOCK),
      .rst   (RESET),
      .we    (locked_we),
      .mask  (mcaps.link_active_report_cap),
      .wdata (wcaps.link_active_report_cap),
      .q     (lact_q)
   );

   lcr_width_fix #(.PHYS_WIDTH(PHYS_WIDTH)) u_wfix (
      .code  (width_q),
      .width (EFFECTIVE_WIDTH)
   );

   always_comb begin
      caps.max_link_speed           = MAX_SPEED;
      caps.max_link_width           = width_q;
      caps.low_power_state_support  = LCR_LPS_SUPPORT;
      caps.l0s_exit_latency         = shared_refclk_config ? LCR_L0S_COMMON : LCR_L0S_SEPARATE;
      caps.l1_exit_latency          = l1_q;
      caps.ref_clock_removal_ok     = clk_rm_q;
      caps.surprise_down_report_cap = sdown_q;
      caps.link_active_report_cap   = lact_q;
      caps.reserved                 = LCR_RSVD_VALUE;
      caps.port_number              = PORT_NUM;
   end

   ////////////////////////////////////////////////////////////////////////////
   // read data and error response

   logic [31:0] next_rdata;

   always_comb begin
      next_rdata = 32'h0000_0000;
      if (hit_caps) begin
         next_rdata = caps;
      end else if (hit_ctrl) begin
         next_rdata[LCR_SHARED_CLK_BIT] = shared_refclk_config;
      end else if (hit_lock) begin
         next_rdata[LCR_UNLOCK_BIT] = unlock;
      end
   end

   // captured at setup; only this transfer can change the bank before access
   always_ff @(posedge CLOCK or posedge RESET) begin
      if (RESET) begin
         PRDATA <= 32'h0000_0000;
      end else if (setup) begin
         PRDATA <= req.pwrite ? 32'h0000_0000 : next_rdata;
      end
   end

   always_ff @(posedge CLOCK or posedge RESET) begin
      if (RESET) begin
         PSLVERR <= 1'b0;
      end else if (setup) begin
         PSLVERR <= ~mapped;
      end else if (!req.psel) begin
         PSLVERR <= 1'b0;
      end
   end

   assign LINK_CAPS     = caps;
   assign SHARED_REFCLK = shared_refclk_config;
   assign REG_UNLOCK    = unlock;

endmodule // lcr_top

// *** verification/lcr_chk.sv ***
// port assertions for the link capabilities register bank
`timescale 1ns/1ns
module lcr_chk #(
   parameter bit         IS_UPSTREAM = 1'b1,
   parameter logic [5:0] PHYS_WIDTH  = 6'h04,
   parameter logic [7:0] PORT_NUM    = 8'h00,
   parameter logic [3:0] MAX_SPEED   = 4'h1
) (
   input wire logic               CLOCK,
   input wire logic               RESET,
   input wire logic               PSEL,
   input wire logic               PENABLE,
   input wire logic               PWRITE,
   input wire logic [11:0]        PADDR,
   input wire logic [31:0]        PWDATA,
   input wire logic [3:0]         PSTRB,
   input wire logic               PREADY,
   input wire logic [31:0]        PRDATA,
   input wire logic               PSLVERR,
   input wire lcr_pkg::lcr_caps_t LINK_CAPS,
   input wire logic [5:0]         EFFECTIVE_WIDTH,
   input wire logic               SHARED_REFCLK,
   input wire logic               REG_UNLOCK
);
   import lcr_pkg::*;
   logic [5:0] w;
   logic       unmapped;
   assign w = LINK_CAPS.max_link_width;
   assign unmapped = PADDR != LCR_LOCK_CTRL_OFS && PADDR != LCR_LINK_CAPS_OFS
      && PADDR != LCR_LINK_CTRL_OFS;
   default clocking @(posedge CLOCK); endclocking
   default disable iff (RESET);
   ////////////////////////////////////////////////////////////////////////////
   sequence s_rd_caps; PSEL && !PENABLE && !PWRITE && PADDR == LCR_LINK_CAPS_OFS; endsequence
   sequence s_wr_caps; PSEL && PENABLE && PWRITE && PADDR == LCR_LINK_CAPS_OFS; endsequence
   property p_speed; LINK_CAPS.max_link_speed == MAX_SPEED; endproperty
   a_speed: assert property (p_speed) else $error("max link speed wrong");
   property p_fixed; LINK_CAPS.low_power_state_support == 2'h3 && LINK_CAPS.reserved == 3'h0
      && LINK_CAPS.port_number == PORT_NUM; endproperty
   a_fixed: assert property (p_fixed) else $error("fixed field wrong");
   property p_l0s; LINK_CAPS.l0s_exit_latency == (SHARED_REFCLK ? 3'h3 : 3'h5); endproperty
   a_l0s: assert property (p_l0s) else $error("l0s latency wrong");
   property p_fix; EFFECTIVE_WIDTH == (((w == 6'h01 || w == 6'h02 || w == 6'h04)
      && w <= PHYS_WIDTH) ? w : 6'h01); endproperty
   a_fix: assert property (p_fix) else $error("effective width wrong");
   property p_rd; s_rd_caps |=> PRDATA == $past(LINK_CAPS); endproperty
   a_rd: assert property (p_rd) else $error("read data differs");
   property p_lock; s_wr_caps ##0 !REG_UNLOCK |=> $stable(LINK_CAPS[20:15]); endproperty
   a_lock: assert property (p_lock) else $error("locked field changed");
   property p_up; s_wr_caps ##0 (IS_UPSTREAM && PSTRB[1:0] == 2'h3)
      |=> w == $past(PWDATA[9:4]); endproperty
   a_up: assert property (p_up) else $error("width not written");
   property p_err; PSEL && !PENABLE && unmapped |=> PSLVERR && PREADY; endproperty
   a_err: assert property (p_err) else $error("no error on unmapped");
endmodule // lcr_chk

bind lcr_top lcr_chk #(.IS_UPSTREAM(IS_UPSTREAM), .PHYS_WIDTH(PHYS_WIDTH),
   .PORT_NUM(PORT_NUM), .MAX_SPEED(MAX_SPEED)) u_chk (.CLOCK(CLOCK), .RESET(RESET),
   .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
   .PSTRB(PSTRB), .PREADY(PREADY), .PRDATA(PRDATA), .PSLVERR(PSLVERR),
   .LINK_CAPS(LINK_CAPS), .EFFECTIVE_WIDTH(EFFECTIVE_WIDTH),
   .SHARED_REFCLK(SHARED_REFCLK), .REG_UNLOCK(REG_UNLOCK));

// *** verification/lcr_tb.sv ***
// self-checking bench for the upstream and downstream link capabilities register banks
`timescale 1ns/1ns
module tb;
   import lcr_pkg::*;
   logic        CLOCK, RESET, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
   logic        SHARED_REFCLK, REG_UNLOCK, err;
   logic [11:0] PADDR;
   logic [31:0] PWDATA, PRDATA, rd;
   logic [3:0]  PSTRB;
   logic [5:0]  EFFECTIVE_WIDTH, c;
   lcr_caps_t   LINK_CAPS, dn_caps;
   logic [5:0]  dn_width;
   int          failures, checked;
   lcr_top dut (.CLOCK(CLOCK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE),
      .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PREADY(PREADY),
      .PRDATA(PRDATA), .PSLVERR(PSLVERR), .LINK_CAPS(LINK_CAPS),
      .EFFECTIVE_WIDTH(EFFECTIVE_WIDTH), .SHARED_REFCLK(SHARED_REFCLK),
      .REG_UNLOCK(REG_UNLOCK));
   // downstream port on the same bus: direction-dependent resets and width lock
   lcr_top #(.IS_UPSTREAM(1'b0), .PORT_NUM(8'h02)) dut_down (.CLOCK(CLOCK), .RESET(RESET),
      .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
      .PSTRB(PSTRB), .PREADY(), .PRDATA(), .PSLVERR(), .LINK_CAPS(dn_caps),
      .EFFECTIVE_WIDTH(dn_width), .SHARED_REFCLK(), .REG_UNLOCK());
   initial begin
      CLOCK = 1'b0;
      forever #5 CLOCK = ~CLOCK;
   end
   ////////////////////////////////////////////////////////////////////////////
   task chk(input string n, input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e) begin
         failures++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask
   // one apb transfer; waits for pready, then lets the edge's updates land
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
      int n;
      @(posedge CLOCK);
      PSEL <= 1'b1;
      PENABLE <= 1'b0;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      PSTRB <= s;
      @(posedge CLOCK);
      PENABLE <= 1'b1;
      n = 0;
      do begin
         @(posedge CLOCK);
         n++;
      end while (PREADY !== 1'b1 && n < 50);
      // a transfer that never completes is a failure in its own right
      if (PREADY !== 1'b1) failures++;
      rd = PRDATA;
      err = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      #1;
   endtask
   function automatic logic [31:0] cw(logic [5:0] w, logic [2:0] l0s, logic [2:0] l1,
                                      logic [2:0] b);
      return {8'h00, 3'h0, b, l1, l0s, 2'h3, w, 4'h1};
   endfunction
   ////////////////////////////////////////////////////////////////////////////
   task t_reset;
      apb(1'b0, LCR_LINK_CAPS_OFS, 32'h0, 4'hf);
      chk("caps at reset", rd, cw(6'h04, 3'h5, 3'h2, 3'h0));
      chk("mapped error", {31'h0, err}, 32'h0);
      chk("down caps reset", dn_caps, {8'h02, 3'h0, 3'h6, 3'h2, 3'h5, 2'h3, 6'h04, 4'h1});
      chk("down eff width", {26'h0, dn_width}, 32'h4);
      apb(1'b0, LCR_LINK_CTRL_OFS, 32'h0, 4'hf);
      chk("link ctrl reset", rd, 32'h0);
      chk("unlock reset", {31'h0, REG_UNLOCK}, 32'h0);
   endtask
   // locked upstream port: only the width field takes the write
   task t_width;
      for (int i = 0; i < 9; i++) begin
         c = 6'(i);
         apb(1'b1, LCR_LINK_CAPS_OFS, {22'h3fffff, c, 4'hf}, 4'hf);
         apb(1'b0, LCR_LINK_CAPS_OFS, 32'h0, 4'hf);
         chk("caps width", rd, cw(c, 3'h5, 3'h2, 3'h0));
         chk("eff width", {26'h0, EFFECTIVE_WIDTH},
             {26'h0, (c == 6'h01 || c == 6'h02 || c == 6'h04) ? c : 6'h01});
         chk("down width locked", {26'h0, dn_caps.max_link_width}, 32'h4);
      end
   endtask
   task t_shared;
      apb(1'b1, LCR_LINK_CTRL_OFS, 32'h40, 4'hf);
      chk("shared clk", {31'h0, SHARED_REFCLK}, 32'h1);
      apb(1'b0, LCR_LINK_CAPS_OFS, 32'h0, 4'hf);
      chk("l0s common", rd, cw(6'h08, 3'h3, 3'h2, 3'h0));
      apb(1'b1, LCR_LINK_CTRL_OFS, 32'h0, 4'hf);
      apb(1'b0, LCR_LINK_CAPS_OFS, 32'h0, 4'hf);
      chk("l0s separate", rd, cw(6'h08, 3'h5, 3'h2, 3'h0));
   endtask
   task t_unlock;
      apb(1'b1, LCR_LOCK_CTRL_OFS, 32'h1, 4'hf);
      chk("unlock set", {31'h0, REG_UNLOCK}, 32'h1);
      apb(1'b0, LCR_LOCK_CTRL_OFS, 32'h0, 4'hf);
      chk("unlock readback", rd, 32'h1);
      apb(1'b1, LCR_LINK_CAPS_OFS, 32'hffffffff, 4'hf);
      apb(1'b0, LCR_LINK_CAPS_OFS, 32'h0, 4'hf);
      chk("unlocked write", rd, cw(6'h3f, 3'h5, 3'h7, 3'h7));
      chk("eff reserved", {26'h0, EFFECTIVE_WIDTH}, 32'h1);
      chk("down unlocked width", {26'h0, dn_caps.max_link_width}, 32'h3f);
      chk("down eff reserved", {26'h0, dn_width}, 32'h1);
      apb(1'b1, LCR_LINK_CAPS_OFS, 32'h0, 4'h4);
      apb(1'b0, LCR_LINK_CAPS_OFS, 32'h0, 4'hf);
      chk("byte lane write", rd, cw(6'h3f, 3'h5, 3'h1, 3'h0));
      apb(1'b1, LCR_LINK_CAPS_OFS, 32'h40, 4'h3);
      apb(1'b1, LCR_LOCK_CTRL_OFS, 32'h0, 4'hf);
      apb(1'b1, LCR_LINK_CAPS_OFS, 32'hffffffff, 4'h4);
      apb(1'b0, LCR_LINK_CAPS_OFS, 32'h0, 4'hf);
      chk("relocked", rd, cw(6'h04, 3'h5, 3'h0, 3'h0));
   endtask
   task t_unmapped;
      apb(1'b1, 12'h044, 32'hffffffff, 4'hf);
      apb(1'b0, 12'h044, 32'h0, 4'hf);
      chk("unmapped error", {31'h0, err}, 32'h1);
      chk("unmapped data", rd, 32'h0);
      chk("unmapped ignored", {30'h0, SHARED_REFCLK, REG_UNLOCK}, 32'h0);
      apb(1'b0, LCR_LINK_CAPS_OFS, 32'h0, 4'hf);
      chk("caps after unmapped", rd, cw(6'h04, 3'h5, 3'h0, 3'h0));
   endtask
   task conclude;
      $display("checks %0d mismatches %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      {RESET, PSEL, PENABLE, PWRITE} = 4'h8;
      PADDR = 12'h0;
      PWDATA = 32'h0;
      PSTRB = 4'h0;
      failures = 0;
      checked = 0;
      repeat (5) @(posedge CLOCK);
      RESET <= 1'b0;
      t_reset;
      t_width;
      t_shared;
      t_unlock;
      t_unmapped;
      conclude;
   end
   // about 40 transfers of three cycles each should finish well inside this
   initial begin
      repeat (3000) @(posedge CLOCK);
      failures++;
      conclude;
   end
endmodule // tb
